// >>> core/sapr_map.vh
// Constants for the parallel readout and conversion sequencer.
// Assumes inclusion by bare name from core/ design files.
`ifndef SAPR_MAP_VH
`define SAPR_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SAPR_CLK_PERIOD_NS 10
`define SAPR_CONV_TIME_NS 2000
`define SAPR_CONV_CYCLES ((`SAPR_CONV_TIME_NS + `SAPR_CLK_PERIOD_NS - 1) / `SAPR_CLK_PERIOD_NS)
// ----------------------------------------
// Result layout
// ----------------------------------------
`define SAPR_RES_W 16
`define SAPR_BYTE_W 8
`define SAPR_MSB 15
`define SAPR_RES_RESET 16'h0000
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define SAPR_ST_TRACK 1'b0
`define SAPR_ST_CONV 1'b1
`endif

// >>> core/sapr_readout.v
// Parallel control and readout of a 16-bit sampling SAR converter.
// Assumes host pins are synchronous to clk_in; the board resolves the bus level from enables.
// A stalled sample source holds busy low instead of dropping a word.
// Abort restarts the count; a buffered sample is kept for the next finish.
// Data lanes and enables are registered, so they trail the host pins by one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "sapr_map.vh"
module sapr_readout #(
  parameter CONV_CYCLES = `SAPR_CONV_CYCLES,
  parameter RES_W = `SAPR_RES_W
) (
  // Clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // Host control
  input wire cs_n_in,
  input wire rd_conv_n_in,
  input wire byte_sel_in,
  input wire byte_mode_in,
  // Sample source, two's complement
  input wire [RES_W-1:0] sample_in,
  input wire sample_valid_in,
  output reg sample_ready_out,
  // Host outputs
  output reg busy_n_out,
  output reg [RES_W-1:0] data_out,
  output reg [RES_W-1:0] data_oe_n_out
);
  // ----------------------------------------
  // Sizing
  // ----------------------------------------
  // Counter width covers the default count with margin; longer counts need a wider CW
  localparam CW = 24;
  localparam integer LAST_I = CONV_CYCLES - 1;
  // LAST is cut to the counter width on purpose
  localparam [CW-1:0] LAST = LAST_I[CW-1:0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg cs_q;
  reg rc_q;
  reg state;
  reg [CW-1:0] count;
  reg [RES_W-1:0] result;
  // ----------------------------------------
  // Two-entry buffer on the sample path
  // ----------------------------------------
  reg [RES_W-1:0] buf_mem [0:1];
  reg [1:0] buf_cnt;
  reg buf_wr;
  reg buf_rd;
  wire buf_pop;
  wire [RES_W-1:0] buf_head;
  wire buf_valid;

  wire start_cmd;
  wire finish;
  wire drive;
  reg [RES_W-1:0] next_data;
  wire buf_take;
  wire [1:0] next_buf_cnt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // A word moves only when both sides agree in the same cycle
  function sapr_take;
    input valid;
    input ready;
    begin
      sapr_take = valid & ready;
    end
  endfunction

  // Occupancy after an edge, given what moves in and what moves out
  function [1:0] sapr_next_cnt;
    input [1:0] cnt;
    input take;
    input pop;
    begin
      case ({take, pop})
        2'b10: sapr_next_cnt = cnt + 2'd1;
        2'b01: sapr_next_cnt = cnt - 2'd1;
        default: sapr_next_cnt = cnt;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Conversion command: both lines low together, starting when the later of the two falls
  assign start_cmd = ~(cs_n_in | rd_conv_n_in) & (cs_q | rc_q);
  // Finishing also needs a sample; a stalled source holds busy low rather than drop data
  assign buf_valid = (buf_cnt != 2'd0);
  assign finish = (state == `SAPR_ST_CONV) && (count >= LAST) && buf_valid && !start_cmd;
  assign buf_pop = finish;
  assign buf_head = buf_mem[buf_rd];
  assign drive = ~cs_n_in & rd_conv_n_in;
  // Board-level three-state buffers take the per-bit enables below
  assign buf_take = sapr_take(sample_valid_in, sample_ready_out);
  assign next_buf_cnt = sapr_next_cnt(buf_cnt, buf_take, buf_pop);

  // ----------------------------------------
  // Buffer storage
  // ----------------------------------------

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      buf_cnt <= 2'd0;
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_mem[0] <= `SAPR_RES_RESET;
      buf_mem[1] <= `SAPR_RES_RESET;
      sample_ready_out <= 1'b0;
    end else begin
      if (buf_take) begin
        buf_mem[buf_wr] <= sample_in;
        buf_wr <= ~buf_wr;
      end
      if (buf_pop) begin
        buf_rd <= ~buf_rd;
      end
      buf_cnt <= next_buf_cnt;
      // Registered ready must judge room after this edge, or a third word slips in
      sample_ready_out <= (next_buf_cnt != 2'd2);
    end
  end

  // ----------------------------------------
  // Pin history
  // ----------------------------------------
  // Idle level is high, so pins already both low when reset releases start a conversion on the first edge
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_q <= 1'b1;
      rc_q <= 1'b1;
    end else begin
      cs_q <= cs_n_in;
      rc_q <= rd_conv_n_in;
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= `SAPR_ST_TRACK;
      count <= {CW{1'b0}};
      result <= `SAPR_RES_RESET;
      busy_n_out <= 1'b1;
    end else begin
      case (state)
        `SAPR_ST_TRACK: begin
          if (start_cmd) begin
            state <= `SAPR_ST_CONV;
            count <= {CW{1'b0}};
            busy_n_out <= 1'b0;
          end
        end
        // Finish waits at the last count until a sample is buffered
        `SAPR_ST_CONV: begin
          if (start_cmd) begin
            count <= {CW{1'b0}};
          end else if (finish) begin
            result <= buf_head;
            state <= `SAPR_ST_TRACK;
            busy_n_out <= 1'b1;
          end else if (count < LAST) begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        // Unreachable with one state bit; kept as a safe return
        default: begin
          state <= `SAPR_ST_TRACK;
          busy_n_out <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output lanes
  // ----------------------------------------
  always @* begin
    next_data = result;
    if (byte_mode_in) begin
      if (!byte_sel_in) begin
        next_data = {{(RES_W-`SAPR_BYTE_W){1'b0}}, result[`SAPR_MSB:`SAPR_BYTE_W]};
      end else begin
        next_data = {{(RES_W-`SAPR_BYTE_W){1'b0}}, result[`SAPR_BYTE_W-1:0]};
      end
    end
  end

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  // Enables go out registered, one cycle behind the pins
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_out <= `SAPR_RES_RESET;
      data_oe_n_out <= {RES_W{1'b1}};
    end else begin
      data_out <= next_data;
      data_oe_n_out <= {RES_W{~drive}};
    end
  end
endmodule // sapr_readout
`default_nettype wire

// >>> dv/sapr_readout_props.sv
// Checker for sapr_readout host pins, bound to every instance.
// Assumes host pins are synchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
module sapr_readout_props #(parameter CONV_CYCLES = 4, parameter RES_W = 16) (
  input wire logic clk_in, input wire logic arst_n_in, input wire logic cs_n_in,
  input wire logic rd_conv_n_in, input wire logic byte_mode_in, input wire logic busy_n_out,
  input wire logic [RES_W-1:0] data_out, input wire logic [RES_W-1:0] data_oe_n_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_start;
    !(cs_n_in | rd_conv_n_in) && $past(cs_n_in | rd_conv_n_in);
  endsequence
  a_start_busy: assert property (s_start |=> !busy_n_out)
    else $error("busy not low");
  a_busy_min: assert property ($fell(busy_n_out) |-> !busy_n_out [*3])
    else $error("busy short");
  a_abort_hold: assert property (s_start ##0 !busy_n_out |=> !busy_n_out [*3])
    else $error("abort released");
  a_cs_float: assert property (cs_n_in |=> &data_oe_n_out)
    else $error("cs float");
  a_conv_float: assert property (!rd_conv_n_in |=> &data_oe_n_out)
    else $error("conv float");
  a_read_drive: assert property (!cs_n_in && rd_conv_n_in |=> data_oe_n_out == 0)
    else $error("not driving");
  a_oe_equal: assert property (&data_oe_n_out || data_oe_n_out == 0)
    else $error("oe split");
  a_byte_upper: assert property (byte_mode_in |=> data_out[RES_W-1:8] == 0)
    else $error("upper lanes");
endmodule // sapr_readout_props
bind sapr_readout sapr_readout_props #(.CONV_CYCLES(CONV_CYCLES), .RES_W(RES_W)) chk_u (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n_in), .rd_conv_n_in(rd_conv_n_in),
  .byte_mode_in(byte_mode_in), .busy_n_out(busy_n_out), .data_out(data_out),
  .data_oe_n_out(data_oe_n_out));
`default_nettype wire

// >>> dv/sapr_readout_tb.sv
// Bench for sapr_readout: table of conversions, then abort, float and full buffer.
// Assumes CONV_CYCLES cut to 4.
`timescale 1ns/10ps
`default_nettype none
module sapr_readout_tb;
  logic clk_in, arst_n_in, cs_n, rd_n, bsel, bmode, go, rdy, busy_n, vld;
  logic [15:0] val, smp, dout, oe_n;
  // Row: mode, select, sample, expected word
  logic [39:0] rows [4] = '{40'h00_8001_8001, 40'h10_7ffe_007f, 40'h11_1234_0034,
    40'h01_ffff_ffff};
  int bad_count = 0, n_checks = 0, cyc = 0;
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (++cyc > 3000) begin
    bad_count++;
    final_report;
  end
  sapr_readout #(.CONV_CYCLES(4)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .cs_n_in(cs_n), .rd_conv_n_in(rd_n), .byte_sel_in(bsel), .byte_mode_in(bmode),
    .sample_in(smp), .sample_valid_in(vld), .sample_ready_out(rdy), .busy_n_out(busy_n),
    .data_out(dout), .data_oe_n_out(oe_n));
  sapr_src src_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go), .ready_in(rdy),
    .val_in(val), .sample_out(smp), .valid_out(vld));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic start;
    cs_n <= 0;
    rd_n <= 0;
    tick(1);
    rd_n <= 1;
    tick(1);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {cs_n, rd_n, bsel, bmode, go, arst_n_in} <= 6'b110000;
    val <= 16'h0000;
    tick(6);
    arst_n_in <= 1;
    tick(2);
    chk("busy_idle", 16'h0001, {15'h0, busy_n});
    foreach (rows[i]) begin
      bmode <= rows[i][36];
      bsel <= rows[i][32];
      val <= rows[i][31:16];
      start;
      tick(6);
      chk("busy_no_sample", 16'h0000, {15'h0, busy_n});
      go <= 1;
      tick(1);
      go <= 0;
      for (int k = 0; k < 50 && busy_n !== 1'b1; k++) tick(1);
      chk("busy_done", 16'h0001, {15'h0, busy_n});
      tick(2);
      chk("data", rows[i][15:0], dout);
      chk("oe_read", 16'h0000, oe_n);
    end
    // Second start two cycles into a conversion must restart the count
    go <= 1;
    start;
    rd_n <= 0;
    tick(1);
    rd_n <= 1;
    tick(4);
    chk("busy_abort", 16'h0000, {15'h0, busy_n});
    cs_n <= 1;
    tick(12);
    chk("oe_float", 16'hffff, oe_n);
    chk("ready_full", 16'h0000, {15'h0, rdy});
    // Convert line low first, then chip select falls and starts
    rd_n <= 0;
    tick(1);
    cs_n <= 0;
    tick(2);
    chk("busy_cs_start", 16'h0000, {15'h0, busy_n});
    final_report;
  end
endmodule // sapr_readout_tb
`default_nettype wire

// >>> dv/sapr_src.sv
// Sample source model: offers a word whenever go is high and none is pending, held until taken.
// Assumes the converter side takes on valid and ready high together.
`timescale 1ns/10ps
`default_nettype none
module sapr_src (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic go_in,
  input wire logic ready_in,
  input wire logic [15:0] val_in,
  output logic [15:0] sample_out,
  output logic valid_out
);
  // Idle word is inverted so a stale value never passes for fresh data
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_out <= 1'b0;
      sample_out <= 16'h0000;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'b0;
      sample_out <= ~sample_out;
    end else if (go_in && !valid_out) begin
      valid_out <= 1'b1;
      sample_out <= val_in;
    end
  end
endmodule // sapr_src
`default_nettype wire
